// File: core/nesr_params.svh
// timing counts and command bytes for the flash erase/status/id/reset controller
`ifndef NESR_PARAMS_SVH
`define NESR_PARAMS_SVH

`define NESR_CLK_NS        10
`define NESR_CEIL_CYC(ns)  (((ns) + `NESR_CLK_NS - 1) / `NESR_CLK_NS)
`define NESR_FLOOR_CYC(ns) ((ns) / `NESR_CLK_NS)

// power-valid recovery, least time
`define NESR_REC_US        10
`define NESR_REC_CYC       `NESR_CEIL_CYC(`NESR_REC_US * 1000)
// strobe widths, least times
`define NESR_WE_LO_NS      40
`define NESR_WE_HI_NS      20
`define NESR_RE_LO_NS      40
`define NESR_RE_HI_NS      20
// wait after a busy-starting latch before sampling ready/busy
`define NESR_WB_NS         100
`define NESR_WE_LO_CYC     `NESR_CEIL_CYC(`NESR_WE_LO_NS)
`define NESR_WE_HI_CYC     `NESR_CEIL_CYC(`NESR_WE_HI_NS)
`define NESR_RE_LO_CYC     `NESR_CEIL_CYC(`NESR_RE_LO_NS)
`define NESR_RE_HI_CYC     `NESR_CEIL_CYC(`NESR_RE_HI_NS)
`define NESR_WB_CYC        `NESR_CEIL_CYC(`NESR_WB_NS)

// command bytes
`define NESR_CMD_READ1     8'h00
`define NESR_CMD_ERASE     8'h60
`define NESR_CMD_CONFIRM   8'hd0
`define NESR_CMD_STATUS    8'h70
`define NESR_CMD_IDENT     8'h90
`define NESR_CMD_RESET     8'hff

// status byte fields
`define NESR_ST_FAIL_BIT   0
`define NESR_ST_READY_BIT  6
`define NESR_ST_WPOFF_BIT  7
`define NESR_ST_RESET_VAL  8'hc0

`endif

// File: core/nesr_pkg.sv
// types shared by the flash erase/status/id/reset controller
`default_nettype none
package nesr_pkg;

   typedef enum logic [1:0] {OP_ERASE, OP_STATUS, OP_IDENT, OP_RESET} nesr_op_e;

   typedef enum logic [2:0] {K_CMD, K_ADDR, K_READ, K_BUSY, K_END} nesr_kind_e;

   typedef enum logic [2:0] {S_PWR, S_IDLE, S_SET, S_ARM, S_LO, S_HI, S_WB, S_RB}
      nesr_state_e;

   typedef struct packed {
      nesr_op_e   op;
      logic [9:0] blk;
   } nesr_req_s;

   typedef struct packed {
      logic       cle;
      logic       ale;
      logic       ce_n;
      logic       we_n;
      logic       output_strobe_n;
      logic       wp_n;
      logic       io_oe;
      logic [7:0] io_out;
   } nesr_pins_s;

   typedef struct packed {
      nesr_state_e st;
      nesr_op_e    op;
      logic [9:0]  blk;
      logic [2:0]  step;
      logic [15:0] cnt;
      logic        rd_idx;
      logic [7:0]  d0;
      logic [7:0]  d1;
      nesr_pins_s  pins;
      logic        req_ready;
      logic        rsp_valid;
      logic        rsp_fail;
      logic        status_mode;
   } nesr_ctl_s;

endpackage
`default_nettype wire

// File: core/nesr_seq.sv
// step table: what each step of each operation puts on the flash pins
`timescale 1ns/1ns
`default_nettype none
`include "nesr_params.svh"

module nesr_seq
(
   // selection
   input  wire nesr_pkg::nesr_op_e   op,
   input  wire logic [2:0]           step,
   input  wire logic [9:0]           blk,
   // step description
   output var  nesr_pkg::nesr_kind_e kind,
   output var  logic [7:0]           byte_out
);

   always_comb
   begin
      kind     = nesr_pkg::K_END;
      byte_out = 8'h00;
      case (op)
         nesr_pkg::OP_ERASE:
         begin
            case (step)
               3'h0:
               begin
                  kind     = nesr_pkg::K_CMD;
                  byte_out = `NESR_CMD_ERASE;
               end
               3'h1:
               begin
                  // block bits land on row bits 5..14; low row bits sent as zero
                  kind     = nesr_pkg::K_ADDR;
                  byte_out = {blk[2:0], 5'h00};
               end
               3'h2:
               begin
                  kind     = nesr_pkg::K_ADDR;
                  byte_out = {1'b0, blk[9:3]};
               end
               3'h3:
               begin
                  kind     = nesr_pkg::K_CMD;
                  byte_out = `NESR_CMD_CONFIRM;
               end
               3'h4:    kind = nesr_pkg::K_BUSY;
               3'h5:
               begin
                  kind     = nesr_pkg::K_CMD;
                  byte_out = `NESR_CMD_STATUS;
               end
               3'h6:    kind = nesr_pkg::K_READ;
               default: kind = nesr_pkg::K_END;
            endcase
         end
         nesr_pkg::OP_STATUS:
         begin
            case (step)
               3'h0:
               begin
                  kind     = nesr_pkg::K_CMD;
                  byte_out = `NESR_CMD_STATUS;
               end
               3'h1:    kind = nesr_pkg::K_READ;
               default: kind = nesr_pkg::K_END;
            endcase
         end
         nesr_pkg::OP_IDENT:
         begin
            case (step)
               3'h0:
               begin
                  kind     = nesr_pkg::K_CMD;
                  byte_out = `NESR_CMD_IDENT;
               end
               3'h1:
               begin
                  kind     = nesr_pkg::K_ADDR;
                  byte_out = 8'h00;
               end
               3'h2:    kind = nesr_pkg::K_READ;
               3'h3:    kind = nesr_pkg::K_READ;
               default: kind = nesr_pkg::K_END;
            endcase
         end
         nesr_pkg::OP_RESET:
         begin
            case (step)
               3'h0:
               begin
                  kind     = nesr_pkg::K_CMD;
                  byte_out = `NESR_CMD_RESET;
               end
               3'h1:    kind = nesr_pkg::K_BUSY;
               default: kind = nesr_pkg::K_END;
            endcase
         end
         default: kind = nesr_pkg::K_END;
      endcase
   end

endmodule
`default_nettype wire

// File: core/nesr_ctrl.sv
// host-side controller driving a small-page flash through erase, status, id and reset
`timescale 1ns/1ns
`default_nettype none
`include "nesr_params.svh"

module nesr_ctrl
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // user request
   input  wire logic                req_valid,
   input  wire nesr_pkg::nesr_req_s req,
   output var  logic                req_ready,
   // user answer
   output var  logic                rsp_valid,
   output var  logic [7:0]          rsp_data0,
   output var  logic [7:0]          rsp_data1,
   output var  logic                rsp_fail,
   output var  logic                status_mode,
   // flash pins
   output var  nesr_pkg::nesr_pins_s pins,
   input  wire logic [7:0]          io_in,
   input  wire logic                ready_busy_n
);

   localparam logic [15:0] REC_CYC   = 16'(`NESR_REC_CYC);
   localparam logic [15:0] WE_LO_CYC = 16'(`NESR_WE_LO_CYC);
   localparam logic [15:0] WE_HI_CYC = 16'(`NESR_WE_HI_CYC);
   localparam logic [15:0] RE_LO_CYC = 16'(`NESR_RE_LO_CYC);
   localparam logic [15:0] RE_HI_CYC = 16'(`NESR_RE_HI_CYC);
   localparam logic [15:0] WB_CYC    = 16'(`NESR_WB_CYC);

   localparam nesr_pkg::nesr_pins_s PINS_RST = '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1,
      we_n: 1'b1, output_strobe_n: 1'b1, wp_n: 1'b0, io_oe: 1'b0, io_out: 8'h00};

   localparam nesr_pkg::nesr_ctl_s CTL_RST = '{st: nesr_pkg::S_PWR,
      op: nesr_pkg::OP_STATUS, blk: 10'h000, step: 3'h0, cnt: REC_CYC - 16'h0001,
      rd_idx: 1'b0, d0: 8'h00, d1: 8'h00, pins: PINS_RST, req_ready: 1'b0,
      rsp_valid: 1'b0, rsp_fail: 1'b0, status_mode: 1'b0};

   nesr_pkg::nesr_ctl_s  s_q;
   nesr_pkg::nesr_ctl_s  s_d;
   nesr_pkg::nesr_kind_e kind;
   logic [7:0]           step_byte;

   function automatic logic is_read(input nesr_pkg::nesr_kind_e k);
      return k == nesr_pkg::K_READ;
   endfunction

   nesr_seq u_seq
   (
      .op       (s_q.op),
      .step     (s_q.step),
      .blk      (s_q.blk),
      .kind     (kind),
      .byte_out (step_byte)
   );

   always_comb
   begin
      s_d           = s_q;
      s_d.rsp_valid = 1'b0;
      case (s_q.st)
         // write protect held low until power recovery ends
         nesr_pkg::S_PWR:
         begin
            s_d.pins.wp_n = 1'b0;
            // no command before recovery count expires
            if (s_q.cnt == 16'h0000)
            begin
               s_d.pins.wp_n = 1'b1;
               s_d.req_ready = 1'b1;
               s_d.st        = nesr_pkg::S_IDLE;
            end
            else
            begin
               s_d.cnt = s_q.cnt - 16'h0001;
            end
         end
         nesr_pkg::S_IDLE:
         begin
            if (req_valid)
            begin
               s_d.op        = req.op;
               s_d.blk       = req.blk;
               s_d.step      = 3'h0;
               s_d.rd_idx    = 1'b0;
               s_d.req_ready = 1'b0;
               s_d.pins.ce_n = 1'b0;
               s_d.st        = nesr_pkg::S_SET;
            end
         end
         nesr_pkg::S_SET:
         begin
            case (kind)
               // CLE for command bytes, ALE for address bytes
               nesr_pkg::K_CMD, nesr_pkg::K_ADDR:
               begin
                  s_d.pins.cle    = kind == nesr_pkg::K_CMD;
                  s_d.pins.ale    = kind == nesr_pkg::K_ADDR;
                  s_d.pins.io_out = step_byte;
                  s_d.pins.io_oe  = 1'b1;
                  s_d.st          = nesr_pkg::S_ARM;
               end
               nesr_pkg::K_READ: s_d.st = nesr_pkg::S_ARM;
               nesr_pkg::K_BUSY:
               begin
                  // ready/busy lags the latch, so it is not sampled at once
                  s_d.cnt = WB_CYC - 16'h0001;
                  s_d.st  = nesr_pkg::S_WB;
               end
               default:
               begin
                  s_d.rsp_valid = 1'b1;
                  s_d.rsp_fail  = (s_q.op == nesr_pkg::OP_ERASE) &&
                                  s_q.d0[`NESR_ST_FAIL_BIT];
                  s_d.pins.ce_n = 1'b1;
                  s_d.req_ready = 1'b1;
                  s_d.st        = nesr_pkg::S_IDLE;
               end
            endcase
         end
         nesr_pkg::S_ARM:
         begin
            if (is_read(kind))
            begin
               s_d.pins.output_strobe_n = 1'b0;
               s_d.cnt                  = RE_LO_CYC - 16'h0001;
            end
            else
            begin
               s_d.pins.we_n = 1'b0;
               s_d.cnt       = WE_LO_CYC - 16'h0001;
            end
            s_d.st = nesr_pkg::S_LO;
         end
         nesr_pkg::S_LO:
         begin
            if (s_q.cnt != 16'h0000)
            begin
               s_d.cnt = s_q.cnt - 16'h0001;
            end
            else if (is_read(kind))
            begin
               // sampled on the last low cycle, just before the strobe rises
               s_d.pins.output_strobe_n = 1'b1;
               s_d.rd_idx               = 1'b1;
               if (s_q.rd_idx)
                  s_d.d1 = io_in;
               else
                  s_d.d0 = io_in;
               s_d.cnt = RE_HI_CYC - 16'h0001;
               s_d.st  = nesr_pkg::S_HI;
            end
            else
            begin
               s_d.pins.we_n = 1'b1;
               // status mode tracks the last command byte
               if (s_q.pins.cle)
                  s_d.status_mode = s_q.pins.io_out == `NESR_CMD_STATUS;
               s_d.cnt = WE_HI_CYC - 16'h0001;
               s_d.st  = nesr_pkg::S_HI;
            end
         end
         nesr_pkg::S_HI:
         begin
            // latch enables and data held through the high phase for hold time
            if (s_q.cnt == 16'h0000)
            begin
               s_d.pins.cle   = 1'b0;
               s_d.pins.ale   = 1'b0;
               s_d.pins.io_oe = 1'b0;
               s_d.step       = s_q.step + 3'h1;
               s_d.st         = nesr_pkg::S_SET;
            end
            else
            begin
               s_d.cnt = s_q.cnt - 16'h0001;
            end
         end
         nesr_pkg::S_WB:
         begin
            if (s_q.cnt == 16'h0000)
               s_d.st = nesr_pkg::S_RB;
            else
               s_d.cnt = s_q.cnt - 16'h0001;
         end
         nesr_pkg::S_RB:
         begin
            // no timeout: a dead device hangs the controller until rst_n
            if (ready_busy_n)
            begin
               s_d.step = s_q.step + 3'h1;
               s_d.st   = nesr_pkg::S_SET;
            end
         end
         default: s_d = CTL_RST;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= CTL_RST;
      else
         s_q <= s_d;
   end

   assign req_ready   = s_q.req_ready;
   assign rsp_valid   = s_q.rsp_valid;
   assign rsp_data0   = s_q.d0;
   assign rsp_data1   = s_q.d1;
   assign rsp_fail    = s_q.rsp_fail;
   assign status_mode = s_q.status_mode;
   assign pins        = s_q.pins;

   // helper state for the checks below
   logic       h_we_q;
   logic [7:0] h_cmd_q;
   logic [1:0] h_addr_q;
   logic [9:0] h_age_q;
   logic       h_latch;

   assign h_latch = s_q.pins.we_n && !h_we_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         h_we_q   <= 1'b1;
         h_cmd_q  <= 8'hff;
         h_addr_q <= 2'h0;
         h_age_q  <= 10'h000;
      end
      else
      begin
         h_we_q <= s_q.pins.we_n;
         if (h_age_q != 10'h3ff)
            h_age_q <= h_age_q + 10'h001;
         if (h_latch && s_q.pins.cle)
         begin
            h_cmd_q  <= s_q.pins.io_out;
            h_addr_q <= 2'h0;
         end
         else if (h_latch && s_q.pins.ale && h_addr_q != 2'h3)
         begin
            h_addr_q <= h_addr_q + 2'h1;
         end
      end
   end

   AST_LATCH_ONE_ENABLE: assert property (@(posedge clk) disable iff (!rst_n)
      h_latch |-> (s_q.pins.cle != s_q.pins.ale) && s_q.pins.io_oe && !s_q.pins.ce_n)
      else $error("write strobe rose without exactly one latch enable and driven data");

   AST_ERASE_TWO_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
      h_latch && s_q.pins.cle && s_q.pins.io_out == `NESR_CMD_CONFIRM
      |-> h_cmd_q == `NESR_CMD_ERASE && h_addr_q == 2'h2)
      else $error("confirm byte not preceded by setup and exactly two address cycles");

   AST_IDENT_ZERO_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
      h_latch && s_q.pins.ale && h_cmd_q == `NESR_CMD_IDENT
      |-> s_q.pins.io_out == 8'h00 && h_addr_q == 2'h0)
      else $error("identify must be followed by a single zero address cycle");

   AST_RECOVERY_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
      !s_q.pins.we_n |-> h_age_q >= 10'(`NESR_REC_CYC))
      else $error("write strobe used before power recovery time");

   AST_WP_LOW_POWERUP: assert property (@(posedge clk) disable iff (!rst_n)
      s_q.st == nesr_pkg::S_PWR |-> !s_q.pins.wp_n && s_q.pins.ce_n && !req_ready)
      else $error("write protect released or chip selected during power-up");

   AST_STATUS_MODE: assert property (@(posedge clk) disable iff (!rst_n)
      h_latch && s_q.pins.cle
      |=> status_mode == $past(s_q.pins.io_out == `NESR_CMD_STATUS, 2))
      else $error("status mode flag does not follow the latched command byte");

endmodule
`default_nettype wire

// File: sim/nesr_flash_model.sv
// behavioural small-page flash answering erase, status, id and reset
`timescale 1ns/1ns
`default_nettype none
`include "nesr_params.svh"
module nesr_flash_model
#(
   // identity values are arbitrary
   parameter logic [7:0] MAKER_CODE  = 8'h5a,
   parameter logic [7:0] DEVICE_CODE = 8'h3c,
   parameter int         ERASE_NS    = 20000,
   parameter int         RESET_NS    = 500
)
(
   // host pins
   input  wire nesr_pkg::nesr_pins_s pins,
   output var  logic [7:0]           dq,
   output var  logic                 rb_pull,
   // test controls
   input  wire logic                 supply_ok,
   input  wire logic                 fail_inject
);
   typedef enum logic [2:0] {M_READ, M_NONE, M_ESET, M_STAT, M_IDW, M_ID} nesr_mode_e;
   nesr_mode_e mode_q = M_READ;
   logic [1:0] acnt = 2'h0;
   logic [7:0] a1 = 8'h00;
   logic [9:0] blk_pend = 10'h000;
   logic [9:0] erase_blk = 10'h000;
   logic       fail = 1'b0;
   logic       in_reset = 1'b0;
   logic       busy = 1'b0;
   logic       id_idx = 1'b0;
   int         erase_cnt = 0;
   int         aborts = 0;
   time        busy_until = 0;
   wire        sel = !pins.ce_n && !pins.output_strobe_n;
   initial dq = 8'h00;
   assign rb_pull = busy;
   always #1
   begin
      busy = ($time < busy_until);
      if (!busy) in_reset = 1'b0;
      if (sel && mode_q == M_STAT) dq = {pins.wp_n, !busy, 5'h00, fail};
      else if (sel && mode_q == M_ID) dq = id_idx ? DEVICE_CODE : MAKER_CODE;
      else dq = ~dq;
   end
   always @(posedge pins.output_strobe_n)
      if (!pins.ce_n && mode_q == M_ID) id_idx = !id_idx;
   always @(posedge pins.we_n)
   begin
      if (supply_ok && !pins.ce_n && pins.cle)
      begin
         if (pins.io_out == `NESR_CMD_RESET)
         begin
            if (!in_reset)
            begin
               if (busy) aborts++;
               in_reset = 1'b1;
               fail = 1'b0;
               mode_q = M_NONE;
               busy_until = $time + RESET_NS;
               busy = 1'b1;
            end
         end
         else if (pins.io_out == `NESR_CMD_STATUS) mode_q = M_STAT;
         else if (!busy)
            case (pins.io_out)
               `NESR_CMD_ERASE:
               begin
                  mode_q = M_ESET;
                  acnt = 2'h0;
               end
               `NESR_CMD_CONFIRM:
                  if (mode_q == M_ESET && acnt == 2'h2)
                  begin
                     erase_cnt++;
                     erase_blk = blk_pend;
                     fail = fail_inject;
                     busy_until = $time + ERASE_NS;
                     busy = 1'b1;
                     mode_q = M_NONE;
                  end
               `NESR_CMD_IDENT: mode_q = M_IDW;
               `NESR_CMD_READ1, 8'h50: mode_q = M_READ;
               default: mode_q = M_NONE;
            endcase
      end
      else if (supply_ok && !pins.ce_n && pins.ale)
      begin
         if (mode_q == M_ESET && acnt < 2'h2)
         begin
            if (acnt == 2'h0) a1 = pins.io_out;
            else blk_pend = {pins.io_out[6:0], a1[7:5]};
            acnt++;
         end
         else if (mode_q == M_IDW && pins.io_out == 8'h00)
         begin
            mode_q = M_ID;
            id_idx = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the flash erase/status/id/reset controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin fails++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb;
   typedef struct packed {
      nesr_pkg::nesr_op_e op;
      logic [9:0]         blk;
      logic               finj;
      logic [7:0]         d0;
      logic [7:0]         d1;
      logic               fail;
      logic               smode;
   } nesr_row_s;
   localparam nesr_pkg::nesr_op_e ER = nesr_pkg::OP_ERASE;
   localparam nesr_pkg::nesr_op_e ST = nesr_pkg::OP_STATUS;
   localparam nesr_pkg::nesr_op_e ID = nesr_pkg::OP_IDENT;
   localparam nesr_pkg::nesr_op_e RS = nesr_pkg::OP_RESET;
   logic                 clk = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 req_valid = 1'b0;
   logic                 fail_inject = 1'b0;
   logic                 supply_ok = 1'b1;
   nesr_pkg::nesr_req_s  req = '0;
   logic                 req_ready, rsp_valid, rsp_fail, status_mode, rb_pull;
   logic [7:0]           rsp_data0, rsp_data1, io_in;
   nesr_pkg::nesr_pins_s pins;
   wire                  ready_busy_n = rb_pull ? 1'b0 : 1'b1;
   int                   fails = 0, total_checks = 0, cyc = 0, n = 0, erases = 0;
   nesr_row_s            rows [8] = '{
      '{ST, 10'h000, 1'b0, 8'hc0, 8'h00, 1'b0, 1'b1},
      '{ID, 10'h000, 1'b0, 8'h5a, 8'h3c, 1'b0, 1'b0},
      '{ER, 10'h3ff, 1'b0, 8'hc0, 8'h00, 1'b0, 1'b1},
      '{ER, 10'h2a5, 1'b1, 8'hc1, 8'h00, 1'b1, 1'b1},
      '{ST, 10'h000, 1'b0, 8'hc1, 8'h00, 1'b0, 1'b1},
      '{RS, 10'h000, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0},
      '{ST, 10'h000, 1'b0, 8'hc0, 8'h00, 1'b0, 1'b1},
      '{ID, 10'h001, 1'b0, 8'h5a, 8'h3c, 1'b0, 1'b0}};
   always #5 clk = ~clk;
   nesr_ctrl u_nesr_ctrl (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data0(rsp_data0),
      .rsp_data1(rsp_data1), .rsp_fail(rsp_fail), .status_mode(status_mode),
      .pins(pins), .io_in(io_in), .ready_busy_n(ready_busy_n));
   nesr_flash_model u_nesr_flash_model (.pins(pins), .dq(io_in), .rb_pull(rb_pull),
      .supply_ok(supply_ok), .fail_inject(fail_inject));
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // waits for idle, hands over one request, waits for its answer
   task automatic run(input nesr_pkg::nesr_op_e op, input logic [9:0] blk);
      n = 0;
      while (req_ready !== 1'b1 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      req_valid <= 1'b1;
      req <= '{op: op, blk: blk};
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      do @(posedge clk); while (rsp_valid !== 1'b1 && ++n < 5000);
      // a request that never answers is a mismatch, not a silent pass
      if (rsp_valid !== 1'b1)
      begin
         fails++;
         conclude();
      end
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         fails++;
         conclude();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      `CHK("wp_n in reset", 1'b0, pins.wp_n)
      `CHK("ce_n in reset", 1'b1, pins.ce_n)
      rst_n <= 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         n++;
         if (n == 500) `CHK("wp_n in recovery", 1'b0, pins.wp_n)
      end
      `CHK("recovery cycles", 1'b1, n >= 995 && n <= 1005)
      `CHK("power-up mode", 3'd0, u_nesr_flash_model.mode_q)
      for (int i = 0; i < 8; i++)
      begin
         fail_inject <= rows[i].finj;
         run(rows[i].op, rows[i].blk);
         if (rows[i].op != RS) `CHK("data0", rows[i].d0, rsp_data0)
         if (rows[i].op == ID) `CHK("data1", rows[i].d1, rsp_data1)
         `CHK("fail flag", rows[i].fail, rsp_fail)
         `CHK("status mode", rows[i].smode, status_mode)
         if (rows[i].op == ER) erases++;
         `CHK("erase count", erases, u_nesr_flash_model.erase_cnt)
         if (rows[i].op == ER) `CHK("erase block", rows[i].blk, u_nesr_flash_model.erase_blk)
      end
      // supply below threshold: the whole erase sequence must be ignored
      supply_ok <= 1'b0;
      run(ER, 10'h0f0);
      `CHK("erase count low supply", erases, u_nesr_flash_model.erase_cnt)
      `CHK("mode low supply", 3'd5, u_nesr_flash_model.mode_q)
      supply_ok <= 1'b1;
      // controller reset in mid-erase, then device reset aborts it
      req_valid <= 1'b1;
      req <= '{op: ER, blk: 10'h155};
      @(posedge clk);
      req_valid <= 1'b0;
      erases++;
      repeat (100) @(posedge clk);
      `CHK("busy in erase", 1'b0, ready_busy_n)
      `CHK("erase count", erases, u_nesr_flash_model.erase_cnt)
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      `CHK("ready in reset", 1'b0, req_ready)
      `CHK("io_oe in reset", 1'b0, pins.io_oe)
      rst_n <= 1'b1;
      // identify while the erase is still busy must be locked out
      run(ID, 10'h000);
      `CHK("lockout mode", 3'd1, u_nesr_flash_model.mode_q)
      run(RS, 10'h000);
      `CHK("reset time", 1'b1, n < 200)
      `CHK("aborts", 1, u_nesr_flash_model.aborts)
      `CHK("mode after reset", 3'd1, u_nesr_flash_model.mode_q)
      run(ST, 10'h000);
      `CHK("status after abort", 8'hc0, rsp_data0)
      conclude();
   end
endmodule
`default_nettype wire
